// ==== interrupt_control_unit.sv ====
// Interrupt control unit: priority, enable and factor flag registers,
// request arbitration towards the CPU core.
// Assumes event pulses, mask bits, nmi and ack come from pclk logic.
`timescale 1ns/100ps

module interrupt_control_unit (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [irq_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire irq_ctrl_pkg::src_events_t src_ev,
  input wire logic nmi_event,
  input wire logic cpu_mask_bit_hi,
  input wire logic cpu_mask_bit_lo,
  input wire logic cpu_ack,
  output irq_ctrl_pkg::irq_req_t irq,
  output logic [1:0] ack_mask,
  output logic mask_load
);
  import irq_ctrl_pkg::*;

  logic [7:0] prio_a_r;
  logic [7:0] prio_b_r;
  logic [7:0] en_tb_r;
  logic [7:0] en_per_r;
  logic [7:0] flag_tb_r;
  logic [7:0] flag_per_r;
  logic nmi_pend_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  irq_req_t irq_r;
  logic [1:0] ack_mask_r;
  logic mask_load_r;

  logic access;
  logic wr_fire;
  logic [15:0] idx;
  logic hit;
  logic [7:0] rd_byte;
  logic [NUM_SRC-1:0] flags_all;
  logic [NUM_SRC-1:0] en_all;
  logic [1:0] cpu_mask;
  irq_req_t irq_nxt;
  logic [1:0] best_lvl;
  logic [3:0] best_idx;
  logic [1:0] src_lvl [NUM_SRC];

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq = irq_r;
  assign ack_mask = ack_mask_r;
  assign mask_load = mask_load_r;

  // Byte address to register index
  function automatic logic [15:0] addr_to_idx(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:2];
  endfunction

  // Source 0 is programmable timer 1, source 14 the 1 Hz clock timer
  function automatic logic [1:0] level_of(input int s, input logic [7:0] pa,
                                          input logic [7:0] pb);
    logic [1:0] l;
    l = 2'h0;
    if (s < 2) begin
      l = pb[PROGTIMER_PRIO_POS +: 2];
    end else if (s == 2) begin
      l = pb[KEYGROUP2_PRIO_POS +: 2];
    end else if (s < 5) begin
      l = pa[KEYGROUP8_PRIO_POS +: 2];
    end else if (s < 8) begin
      l = pa[SERIAL_PRIO_POS +: 2];
    end else if (s < 11) begin
      l = pa[STOPWATCH_PRIO_POS +: 2];
    end else begin
      l = pa[CLOCKTIMER_PRIO_POS +: 2];
    end
    return l;
  endfunction

  assign idx = addr_to_idx(paddr);
  assign access = psel && penable;
  // Write lands only at the edge where pready is seen high
  assign wr_fire = access && pready_r && pwrite && hit;
  assign flags_all = {flag_per_r, flag_tb_r[6:0]};
  assign en_all = {en_per_r, en_tb_r[6:0]};
  assign cpu_mask = {cpu_mask_bit_hi, cpu_mask_bit_lo};

  always_comb begin
    hit = 1'b1;
    rd_byte = 8'h00;
    case (idx)
      IDX_PRIO_A: rd_byte = prio_a_r;
      IDX_PRIO_B: rd_byte = prio_b_r;
      IDX_EN_TB: rd_byte = en_tb_r;
      IDX_EN_PER: rd_byte = en_per_r;
      IDX_FLAG_TB: rd_byte = flag_tb_r;
      IDX_FLAG_PER: rd_byte = flag_per_r;
      default: hit = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= access && !pready_r;
      pslverr_r <= access && !pready_r && !hit;
      if (access && !pready_r) begin
        prdata_r <= {24'h00_0000, rd_byte};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_a_r <= REG_RESET;
      prio_b_r <= REG_RESET;
    end else if (wr_fire && idx == IDX_PRIO_A) begin
      prio_a_r <= pwdata[7:0];
    end else if (wr_fire && idx == IDX_PRIO_B) begin
      prio_b_r <= pwdata[7:0] & PRIO_B_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_tb_r <= REG_RESET;
      en_per_r <= REG_RESET;
    end else if (wr_fire && idx == IDX_EN_TB) begin
      en_tb_r <= pwdata[7:0] & TB_MASK;
    end else if (wr_fire && idx == IDX_EN_PER) begin
      en_per_r <= pwdata[7:0];
    end
  end

  // flags: a set in the same cycle beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_tb_r <= REG_RESET;
      flag_per_r <= REG_RESET;
    end else begin
      flag_tb_r <= ((flag_tb_r & ~((wr_fire && idx == IDX_FLAG_TB) ? pwdata[7:0] : 8'h00))
                    | {1'b0, src_ev.tb}) & TB_MASK;
      flag_per_r <= (flag_per_r & ~((wr_fire && idx == IDX_FLAG_PER) ? pwdata[7:0] : 8'h00))
                    | src_ev.per;
    end
  end

  // Watchdog request held until the CPU takes it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi_pend_r <= 1'b0;
    end else if (nmi_event) begin
      nmi_pend_r <= 1'b1;
    end else if (cpu_ack && irq_r.valid && irq_r.level == LEVEL_NMI) begin
      nmi_pend_r <= 1'b0;
    end
  end

  // per-source level, zero unless flag and enable
  generate
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
      assign src_lvl[g] = (flags_all[NUM_SRC-1-g] && en_all[NUM_SRC-1-g])
                          ? level_of(g, prio_a_r, prio_b_r) : 2'h0;
    end
  endgenerate

  // scan from lowest priority so the earlier source wins ties
  always_comb begin
    best_lvl = 2'h0;
    best_idx = 4'h0;
    for (int k = NUM_SRC - 1; k >= 0; k--) begin
      if (src_lvl[k] != 2'h0 && src_lvl[k] >= best_lvl) begin
        best_lvl = src_lvl[k];
        best_idx = 4'(k);
      end
    end
  end

  always_comb begin
    irq_nxt = '0;
    if (nmi_pend_r) begin
      irq_nxt.valid = 1'b1;
      irq_nxt.level = LEVEL_NMI;
      irq_nxt.vector = VEC_NMI;
    end else if (best_lvl > cpu_mask) begin
      irq_nxt.valid = 1'b1;
      irq_nxt.level = {1'b0, best_lvl};
      irq_nxt.vector = VEC_FIRST_SRC + {3'h0, best_idx, 1'b0};
    end
  end

  // request follows live flags, so it returns
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= '0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // new mask value handed to the core on acceptance
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_mask_r <= 2'h0;
      mask_load_r <= 1'b0;
    end else begin
      mask_load_r <= cpu_ack && irq_r.valid;
      if (cpu_ack && irq_r.valid) begin
        ack_mask_r <= (irq_r.level == LEVEL_NMI) ? MASK_AFTER_NMI : irq_r.level[1:0];
      end
    end
  end

  sequence s_setup;
    psel && !penable;
  endsequence

  sequence s_first_access;
    psel && penable && !pready_r;
  endsequence

  property p_apb_wait;
    @(posedge pclk) disable iff (!presetn)
    s_setup ##1 s_first_access |=> pready_r;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready not raised");

  property p_flag_set;
    @(posedge pclk) disable iff (!presetn)
    src_ev.per != 8'h00 |=> (flag_per_r & $past(src_ev.per)) == $past(src_ev.per);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_flag_clear;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && idx == IDX_FLAG_TB && pwdata[0] && !src_ev.tb[0] |=> !flag_tb_r[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_reserved_zero;
    @(posedge pclk) disable iff (!presetn)
    prio_b_r[7:4] == 4'h0 && !en_tb_r[7] && !flag_tb_r[7];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_enable_readback;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && idx == IDX_EN_PER |=> en_per_r == $past(pwdata[7:0]);
  endproperty
  a_enable_readback: assert property (p_enable_readback) else $error("enable lost");

  property p_above_mask;
    @(posedge pclk) disable iff (!presetn)
    irq_r.valid && irq_r.level != LEVEL_NMI |-> irq_r.level > {1'b0, $past(cpu_mask)};
  endproperty
  a_above_mask: assert property (p_above_mask) else $error("masked level sent");

  property p_nmi_first;
    @(posedge pclk) disable iff (!presetn)
    nmi_event |=> ##1 irq_r.valid && irq_r.level == LEVEL_NMI && irq_r.vector == VEC_NMI;
  endproperty
  a_nmi_first: assert property (p_nmi_first) else $error("nmi not presented");

  property p_disabled_quiet;
    @(posedge pclk) disable iff (!presetn)
    en_tb_r == 8'h00 && en_per_r == 8'h00 && !nmi_pend_r |=> !irq_r.valid;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("request while off");

  property p_ack_mask;
    @(posedge pclk) disable iff (!presetn)
    cpu_ack && irq_r.valid && irq_r.level == 3'h2 |=> mask_load_r && ack_mask_r == 2'h2;
  endproperty
  a_ack_mask: assert property (p_ack_mask) else $error("mask after ack wrong");

  property p_rerequest;
    @(posedge pclk) disable iff (!presetn)
    flag_per_r[7] && en_per_r[7] && prio_b_r[3:2] == 2'h3 && cpu_mask != 2'h3
      && !nmi_pend_r |=> irq_r.valid && irq_r.vector == VEC_FIRST_SRC;
  endproperty
  a_rerequest: assert property (p_rerequest) else $error("pending not requested");

  // Bits written zero keep their state unless their source fires
  property p_flag_keep;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && idx == IDX_FLAG_PER |=> ((flag_per_r ^ $past(flag_per_r))
      & ~$past(pwdata[7:0]) & ~$past(src_ev.per)) == 8'h00;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag changed by zero write");

  property p_prio_b_readback;
    @(posedge pclk) disable iff (!presetn)
    wr_fire && idx == IDX_PRIO_B |=> prio_b_r == ($past(pwdata[7:0]) & PRIO_B_MASK);
  endproperty
  a_prio_b_readback: assert property (p_prio_b_readback) else $error("prio b wrong");

  property p_level_zero_quiet;
    @(posedge pclk) disable iff (!presetn)
    prio_a_r == 8'h00 && prio_b_r == 8'h00 && !nmi_pend_r |=> !irq_r.valid;
  endproperty
  a_level_zero_quiet: assert property (p_level_zero_quiet) else $error("level 0 sent");

  property p_nmi_ack_mask;
    @(posedge pclk) disable iff (!presetn)
    cpu_ack && irq_r.valid && irq_r.level == LEVEL_NMI
      |=> mask_load_r && ack_mask_r == MASK_AFTER_NMI;
  endproperty
  a_nmi_ack_mask: assert property (p_nmi_ack_mask) else $error("mask after nmi wrong");

  // Unmapped index answers with an error in the same wait state
  property p_unmapped_err;
    @(posedge pclk) disable iff (!presetn)
    s_first_access ##0 !hit |=> pready_r && pslverr_r;
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("no error on unmapped");

endmodule // interrupt_control_unit

// ==== irq_ctrl_pkg.sv ====
// Package for the interrupt control unit: register indexes, layouts,
// reset values and carrier types.
// Assumes a 32-bit APB with each byte register in the low bits of a word.
package irq_ctrl_pkg;

  localparam int ADDR_W = 18;
  localparam int NUM_SRC = 15;

  // Register indexes; byte address is four times the index
  localparam logic [15:0] IDX_PRIO_A = 16'hff20;
  localparam logic [15:0] IDX_PRIO_B = 16'hff21;
  localparam logic [15:0] IDX_EN_TB = 16'hff22;
  localparam logic [15:0] IDX_EN_PER = 16'hff23;
  localparam logic [15:0] IDX_FLAG_TB = 16'hff24;
  localparam logic [15:0] IDX_FLAG_PER = 16'hff25;

  // Field positions
  localparam int KEYGROUP8_PRIO_POS = 6;
  localparam int SERIAL_PRIO_POS = 4;
  localparam int STOPWATCH_PRIO_POS = 2;
  localparam int CLOCKTIMER_PRIO_POS = 0;
  localparam int PROGTIMER_PRIO_POS = 2;
  localparam int KEYGROUP2_PRIO_POS = 0;

  // Writable bits of priority B and the time-base bytes, and the reset value
  localparam logic [7:0] PRIO_B_MASK = 8'h0f;
  localparam logic [7:0] TB_MASK = 8'h7f;
  localparam logic [7:0] REG_RESET = 8'h00;

  // Levels and vectors
  localparam logic [2:0] LEVEL_NMI = 3'h4;
  localparam logic [1:0] MASK_AFTER_NMI = 2'h3;
  localparam logic [7:0] VEC_NMI = 8'h04;
  localparam logic [7:0] VEC_FIRST_SRC = 8'h06;

  typedef struct packed {
    logic [7:0] per;
    logic [6:0] tb;
  } src_events_t;

  typedef struct packed {
    logic valid;
    logic [2:0] level;
    logic [7:0] vector;
  } irq_req_t;

endpackage

// ==== cpu_core_model.sv ====
// CPU core stand-in: takes requests above its mask level, then loads the mask.
// Assumes irq and mask_load come from the unit on pclk.
`timescale 1ns/100ps
module cpu_core_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire irq_ctrl_pkg::irq_req_t irq,
  input wire logic [1:0] ack_mask,
  input wire logic mask_load,
  input wire logic auto_ack,
  input wire logic set_mask,
  input wire logic [1:0] new_mask,
  output logic cpu_mask_bit_hi,
  output logic cpu_mask_bit_lo,
  output logic cpu_ack
);
  import irq_ctrl_pkg::*;
  logic [1:0] hold_r;
  // above mask, NMI always
  // Hold-off covers the unit's mask-to-request lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_ack <= 1'b0;
      hold_r <= 2'h0;
    end else if (auto_ack && hold_r == 2'h0 && irq.valid && (irq.level == LEVEL_NMI
        || irq.level > {1'b0, cpu_mask_bit_hi, cpu_mask_bit_lo})) begin
      cpu_ack <= 1'b1;
      hold_r <= 2'h3;
    end else begin
      cpu_ack <= 1'b0;
      hold_r <= (hold_r == 2'h0) ? 2'h0 : hold_r - 2'h1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cpu_mask_bit_hi, cpu_mask_bit_lo} <= 2'h0;
    end else if (mask_load) begin
      {cpu_mask_bit_hi, cpu_mask_bit_lo} <= ack_mask;
    end else if (set_mask) begin
      {cpu_mask_bit_hi, cpu_mask_bit_lo} <= new_mask;
    end
  end
endmodule // cpu_core_model

// ==== interrupt_control_unit_tb_top.sv ====
// Bench for the interrupt control unit: registers, flags, arbitration.
// Assumes the CPU core model answers requests.
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin errors++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end
module interrupt_control_unit_tb_top;
  import irq_ctrl_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, nmi_event = 0;
  logic auto_ack = 0, set_mask = 0, pready, pslverr, err, cpu_ack, mask_load;
  logic cpu_mask_bit_hi, cpu_mask_bit_lo;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [1:0] new_mask = '0, ack_mask;
  src_events_t src_ev = '0;
  irq_req_t irq;
  int errors = 0, total_checks = 0;
  always #25 pclk = ~pclk;
  interrupt_control_unit dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .src_ev, .nmi_event, .cpu_mask_bit_hi, .cpu_mask_bit_lo,
    .cpu_ack, .irq, .ack_mask, .mask_load);
  cpu_core_model cpu (.pclk, .presetn, .irq, .ack_mask, .mask_load, .auto_ack, .set_mask,
    .new_mask, .cpu_mask_bit_hi, .cpu_mask_bit_lo, .cpu_ack);
  task automatic summarize();
    if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
    int i = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, idx, 2'b00, 24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1 && ++i < 20);
    if (pready !== 1'b1) begin
      errors++;
      summarize();
    end
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [7:0] x);
    apb(1'b0, idx, 8'h00);
    `CHK({err, rd}, {25'h0, x})
  endtask
  task automatic pulse(input logic [14:0] ev, input logic n);
    @(posedge pclk);
    {src_ev, nmi_event} <= {ev, n};
    @(posedge pclk);
    {src_ev, nmi_event} <= 16'h0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic setm(input logic [1:0] m);
    @(posedge pclk);
    {set_mask, new_mask} <= {1'b1, m};
    @(posedge pclk);
    set_mask <= 1'b0;
    repeat (6) @(posedge pclk);
  endtask
  // Priority A, priority B, time-base enables, peripheral enables
  task automatic wr4(input logic [31:0] v);
    for (int k = 0; k < 4; k++) apb(1'b1, IDX_PRIO_A + 16'(k), v[8*k +: 8]);
  endtask
  task automatic clr();
    apb(1'b1, IDX_FLAG_PER, 8'hff);
    apb(1'b1, IDX_FLAG_TB, 8'h7f);
  endtask
  initial begin
    logic [31:0] r;
    logic [14:0] ev, cl;
    logic [11:0] p;
    logic [1:0] lv;
    logic [7:0] v;
    logic [7:0] msk [4];
    msk = '{8'hff, PRIO_B_MASK, TB_MASK, 8'hff};
    void'($urandom(71));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, 16'h0100, 8'hff);
    `CHK(err, 1'b1)
    for (int k = 0; k < 6; k++) rdc(IDX_PRIO_A + 16'(k), REG_RESET);
    for (int k = 0; k < 32; k++) begin
      r = $urandom;
      apb(1'b1, IDX_PRIO_A + 16'(k % 4), r[7:0]);
      rdc(IDX_PRIO_A + 16'(k % 4), r[7:0] & msk[k % 4]);
    end
    for (int k = 0; k < 8; k++) begin
      ev = 15'($urandom);
      cl = 15'($urandom);
      pulse(ev, 1'b0);
      rdc(IDX_FLAG_PER, ev[14:7]);
      rdc(IDX_FLAG_TB, {1'b0, ev[6:0]});
      apb(1'b1, IDX_FLAG_PER, cl[14:7]);
      apb(1'b1, IDX_FLAG_TB, {1'b1, cl[6:0]});
      rdc(IDX_FLAG_PER, ev[14:7] & ~cl[14:7]);
      rdc(IDX_FLAG_TB, {1'b0, ev[6:0] & ~cl[6:0]});
      clr();
    end
    for (int s = 0; s < 15; s++) begin
      lv = 2'($urandom_range(3, 1));
      p = 12'(lv) << (s < 2 ? 10 : s < 3 ? 8 : s < 5 ? 6 : s < 8 ? 4 : s < 11 ? 2 : 0);
      ev = 15'h1 << (14 - s);
      wr4({ev[14:7], 1'b0, ev[6:0], 4'h0, p});
      pulse(ev, 1'b0);
      `CHK(irq, irq_req_t'({2'b10, lv, VEC_FIRST_SRC + 8'(2 * s)}))
      wr4(s[0] ? {ev[14:7], 1'b0, ev[6:0], 16'h0} : {20'h0, p});
      repeat (3) @(posedge pclk);
      `CHK(irq.valid, 1'b0)
      clr();
    end
    wr4(32'hff7f0fff);
    for (int k = 0; k < 8; k++) begin
      // Corner: first round ties source 0 with the lowest source
      ev = 15'($urandom) | (k == 0 ? 15'h4001 : 15'h1);
      pulse(ev, 1'b0);
      for (int b = 0; b < 15; b++) if (ev[b]) v = VEC_FIRST_SRC + 8'(2 * (14 - b));
      `CHK(irq.vector, v)
      clr();
    end
    wr4(32'h10000080);
    setm(2'h2);
    pulse(15'h0800, 1'b0);
    `CHK(irq.valid, 1'b0)
    setm(2'h1);
    `CHK(irq, irq_req_t'({4'ha, VEC_FIRST_SRC + 8'h06}))
    auto_ack <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK({ack_mask, cpu_mask_bit_hi, cpu_mask_bit_lo, irq.valid}, 5'b10100)
    setm(2'h0);
    `CHK({cpu_mask_bit_hi, cpu_mask_bit_lo}, 2'h2)
    clr();
    setm(2'h0);
    `CHK({cpu_mask_bit_hi, cpu_mask_bit_lo, irq.valid}, 3'h0)
    auto_ack <= 1'b0;
    setm(2'h3);
    pulse(15'h0, 1'b1);
    `CHK(irq, irq_req_t'({1'b1, LEVEL_NMI, VEC_NMI}))
    auto_ack <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK({ack_mask, irq.valid}, {MASK_AFTER_NMI, 1'b0})
    summarize();
  end
endmodule // interrupt_control_unit_tb_top
